/* rtl/umcr_ctl_if.sv */
`timescale 1ns/1ps
// control bits handed from the register file to the datapath
interface umcr_ctl_if;
  logic div4;
  logic loopback;
  logic rts_bit;
  logic dtr_bit;

  modport ctl (output div4, loopback, rts_bit, dtr_bit);
  modport dp  (input  div4, loopback, rts_bit, dtr_bit);
endinterface

/* rtl/umcr_loop.sv */
`timescale 1ns/1ps
// serial and modem line routing, with internal loopback
module umcr_loop (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  umcr_ctl_if.dp    ctl,
  input  wire logic tx_core_i,
  input  wire logic rx_pin_i,
  input  wire logic cts_n_i,
  input  wire logic dsr_n_i,
  output logic      tx_o,
  output logic      rx_core_o,
  output logic      mls_cts_o,
  output logic      mls_dsr_o
);
  import umcr_pkg::*;

  wire tx_nxt;
  wire rx_nxt;
  wire cts_nxt;
  wire dsr_nxt;

  assign tx_nxt  = ctl.loopback ? 1'b1 : tx_core_i;  // pin idles at mark
  assign rx_nxt  = ctl.loopback ? tx_core_i : rx_pin_i;
  assign cts_nxt = ctl.loopback ? ctl.rts_bit : !cts_n_i;
  assign dsr_nxt = ctl.loopback ? ctl.dtr_bit : !dsr_n_i;

  // registered line outputs
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_o      <= 1'b1;
      rx_core_o <= 1'b1;
      mls_cts_o <= 1'b0;
      mls_dsr_o <= 1'b0;
    end else begin
      tx_o      <= tx_nxt;
      rx_core_o <= rx_nxt;
      mls_cts_o <= cts_nxt;
      mls_dsr_o <= dsr_nxt;
    end
  end
endmodule

/* rtl/umcr_pkg.sv */
package umcr_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int          ADDR_W     = 5;
  localparam int          DATA_W     = 32;
  localparam int          GPIO_W     = 8;
  localparam logic [4:0]  OFF_MLC    = 5'h00;  // modem_line_control
  localparam logic [4:0]  OFF_EFR    = 5'h04;  // enhanced_feature_reg
  localparam logic [4:0]  OFF_IOCFG  = 5'h08;  // io_pin_config_reg
  localparam logic [4:0]  OFF_IOLVL  = 5'h0C;  // io_pin_level_reg
  localparam logic [4:0]  OFF_MLS    = 5'h10;  // modem_line_status
  localparam logic [4:0]  OFF_IODIR  = 5'h14;  // general pin direction

  // ************************************************************
  // modem_line_control fields
  // ************************************************************
  localparam int          MLC_DIV4   = 7;
  localparam int          MLC_IRDA   = 6;
  localparam int          MLC_XANY   = 5;
  localparam int          MLC_LOOP   = 4;
  localparam int          MLC_THR    = 2;
  localparam int          MLC_RTS    = 1;
  localparam int          MLC_DTR    = 0;
  localparam logic [7:0]  MLC_GATED  = 8'hE4;  // bits 7:5 and 2
  localparam logic [7:0]  MLC_FREE   = 8'h13;  // bits 4, 1, 0
  localparam logic [7:0]  MLC_RST    = 8'h00;

  // ************************************************************
  // other fields and reset values
  // ************************************************************
  localparam int          EFR_WEN    = 4;
  localparam int          EFR_ARTS   = 6;
  localparam int          IOCFG_DTR5 = 1;
  localparam int          IOCFG_DTR1 = 2;
  localparam int          DTR_PIN_A  = 5;
  localparam int          DTR_PIN_B  = 1;
  localparam int          MLS_CTS    = 4;
  localparam int          MLS_DSR    = 5;
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [1:0]  PRE_DIV4   = 2'h3;  // last count of divide by 4

endpackage

/* rtl/umcr_prescale.sv */
`timescale 1ns/1ps
// input clock prescaler: a tick every cycle or every fourth
module umcr_prescale (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  umcr_ctl_if.dp    ctl,
  output logic      tick_o
);
  import umcr_pkg::*;

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       wrap;

  // count wraps at the divide-by-4 end, or every cycle
  assign wrap    = !ctl.div4 || (cnt_r == PRE_DIV4);
  assign cnt_nxt = wrap ? 2'h0 : 2'(cnt_r + 2'h1);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r  <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_o <= wrap;
    end
  end
endmodule

/* rtl/umcr_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - Bit 7 set divides the input clock by four before baud use, else by one.
// - Bit 6 set puts the channel in infrared mode, clear gives plain UART.
// - Bit 5 set enables resume on any received character.
// - Bit 4 set loops the transmit output into the receive input inside.
// - In loopback the two low control bits appear as status bits 4 and 5.
// - Bit 2 set opens access to the threshold and trigger level registers.
// - Bit 1 at 0 drives the active-low RTS high, at 1 drives it low.
// - With automatic RTS enabled the flow logic drives RTS instead of bit 1.
// - Bit 0 drives DTR only on a general pin configured as DTR.
// - Level register writes leave a general pin serving as DTR unchanged.
// - On a DTR pin bit 0 at 0 gives high, and bit 0 at 1 gives low.
// - Bits 7 to 5 and bit 2 change only while the feature write enable is set.
module umcr_top #(
  parameter int GPIO_W = umcr_pkg::GPIO_W
) (
  input  wire logic                          clock_i,
  input  wire logic                          sys_rst_i,
  // Avalon-MM slave
  input  wire logic [umcr_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [umcr_pkg::DATA_W-1:0]   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [umcr_pkg::DATA_W-1:0]   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  // channel core side
  input  wire logic                          tx_core_i,
  input  wire logic                          hw_rts_n_i,
  output logic                               rx_core_o,
  output logic                               baud_tick_o,
  output logic                               irda_mode_o,
  output logic                               xon_any_o,
  output logic                               thr_access_o,
  // modem and serial pins
  input  wire logic                          rx_i,
  input  wire logic                          cts_n_i,
  input  wire logic                          dsr_n_i,
  output logic                               tx_o,
  output logic                               rts_n_o,
  // general pins, two-way
  input  wire logic [GPIO_W-1:0]             gpio_i,
  output logic      [GPIO_W-1:0]             gpio_o,
  output logic      [GPIO_W-1:0]             gpio_oe_n_o
);
  import umcr_pkg::*;

  localparam int SYNC_W = GPIO_W + 3;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  wire               rx_s;
  wire               cts_n_s;
  wire               dsr_n_s;
  wire  [GPIO_W-1:0] gpio_s;

  // two flops on every pin input
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= {gpio_i, dsr_n_i, cts_n_i, rx_i};
      sync2_r <= sync1_r;
    end
  end

  // synchronised pin levels
  assign rx_s    = sync2_r[0];
  assign cts_n_s = sync2_r[1];
  assign dsr_n_s = sync2_r[2];
  assign gpio_s  = sync2_r[SYNC_W-1:3];

  // ************************************************************
  // register storage
  // ************************************************************
  logic [7:0]        mlc_r;
  logic [7:0]        mlc_nxt;
  logic [7:0]        efr_r;
  logic [7:0]        iocfg_r;
  logic [GPIO_W-1:0] iolvl_r;
  logic [GPIO_W-1:0] iodir_r;
  logic              wait_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [7:0]        mlc_mask;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire [4:0] word_addr;
  wire       req;
  wire       take;
  wire       wr_take;
  wire       wr_lane0;
  wire       sel_mlc;
  wire       sel_efr;
  wire       sel_iocfg;
  wire       sel_iolvl;
  wire       sel_mls;
  wire       sel_iodir;
  wire [7:0] wbyte;

  // aligned word select, low address bits ignored
  assign word_addr = {avs_address_i[4:2], 2'b00};
  assign req       = avs_read_i || avs_write_i;
  assign take      = req && !wait_r;
  assign wr_take   = take && avs_write_i;
  assign wr_lane0  = wr_take && avs_byteenable_i[0];
  assign wbyte     = avs_writedata_i[7:0];
  assign sel_mlc   = (word_addr == OFF_MLC);
  assign sel_efr   = (word_addr == OFF_EFR);
  assign sel_iocfg = (word_addr == OFF_IOCFG);
  assign sel_iolvl = (word_addr == OFF_IOLVL);
  assign sel_mls   = (word_addr == OFF_MLS);
  assign sel_iodir = (word_addr == OFF_IODIR);

  // one wait cycle per request, then a one-cycle acknowledge
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !(req && wait_r);
    end
  end

  // ************************************************************
  // modem_line_control write path
  // ************************************************************

  assign mlc_mask = efr_r[EFR_WEN] ? (MLC_GATED | MLC_FREE) : MLC_FREE;

  assign mlc_nxt = (mlc_r & ~mlc_mask) | (wbyte & mlc_mask);

  // control registers written over the bus
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mlc_r   <= MLC_RST;
      efr_r   <= REG_RST;
      iocfg_r <= REG_RST;
    end else if (wr_lane0) begin
      if (sel_mlc) begin
        mlc_r <= mlc_nxt;
      end
      if (sel_efr) begin
        efr_r <= wbyte;
      end
      if (sel_iocfg) begin
        iocfg_r <= wbyte;
      end
    end
  end

  // general pin level and direction
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      iolvl_r <= '0;
      iodir_r <= '0;
    end else if (wr_lane0) begin
      if (sel_iolvl) begin
        iolvl_r <= wbyte[GPIO_W-1:0];
      end
      if (sel_iodir) begin
        iodir_r <= wbyte[GPIO_W-1:0];
      end
    end
  end

  // ************************************************************
  // datapath modules
  // ************************************************************
  umcr_ctl_if ctl_if ();
  wire        mls_cts;
  wire        mls_dsr;

  // control bits onto the carrier
  assign ctl_if.div4     = mlc_r[MLC_DIV4];
  assign ctl_if.loopback = mlc_r[MLC_LOOP];
  assign ctl_if.rts_bit  = mlc_r[MLC_RTS];
  assign ctl_if.dtr_bit  = mlc_r[MLC_DTR];

  umcr_prescale u_prescale (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ctl       (ctl_if.dp),
    .tick_o    (baud_tick_o)
  );

  umcr_loop u_loop (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ctl       (ctl_if.dp),
    .tx_core_i (tx_core_i),
    .rx_pin_i  (rx_s),
    .cts_n_i   (cts_n_s),
    .dsr_n_i   (dsr_n_s),
    .tx_o      (tx_o),
    .rx_core_o (rx_core_o),
    .mls_cts_o (mls_cts),
    .mls_dsr_o (mls_dsr)
  );

  // ************************************************************
  // read path
  // ************************************************************
  wire [7:0] mls_val;
  wire [7:0] lvl_val;
  wire [7:0] dir_val;

  assign mls_val = {2'b00, mls_dsr, mls_cts, 4'h0};
  assign lvl_val = 8'(gpio_s);
  assign dir_val = 8'(iodir_r);

  // read mux, unmapped words read zero
  always_comb begin
    rdata_nxt = '0;
    if (sel_mlc) begin
      rdata_nxt[7:0] = mlc_r;
    end else if (sel_efr) begin
      rdata_nxt[7:0] = efr_r;
    end else if (sel_iocfg) begin
      rdata_nxt[7:0] = iocfg_r;
    end else if (sel_iolvl) begin
      rdata_nxt[7:0] = lvl_val;
    end else if (sel_mls) begin
      rdata_nxt[7:0] = mls_val;
    end else if (sel_iodir) begin
      rdata_nxt[7:0] = dir_val;
    end
  end

  // read data loaded in the wait cycle, stands at the acknowledge
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= '0;
    end else if (req && wait_r && avs_read_i) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

  // waitrequest straight from its flop
  assign avs_waitrequest_o = wait_r;

  // ************************************************************
  // modem control outputs
  // ************************************************************
  wire rts_n_nxt;
  wire [GPIO_W-1:0] dtr_sel;
  wire [GPIO_W-1:0] gpio_nxt;
  wire [GPIO_W-1:0] gpio_oe_n_nxt;

  assign rts_n_nxt = efr_r[EFR_ARTS] ? hw_rts_n_i : !mlc_r[MLC_RTS];

  genvar g;
  generate
    for (g = 0; g < GPIO_W; g++) begin : g_pin
      if (g == DTR_PIN_A) begin : g_a
        assign dtr_sel[g] = iocfg_r[IOCFG_DTR5];
      end else if (g == DTR_PIN_B) begin : g_b
        assign dtr_sel[g] = iocfg_r[IOCFG_DTR1];
      end else begin : g_n
        assign dtr_sel[g] = 1'b0;
      end
      assign gpio_nxt[g] = dtr_sel[g] ? !mlc_r[MLC_DTR] : iolvl_r[g];
      assign gpio_oe_n_nxt[g] = !(dtr_sel[g] || iodir_r[g]);
    end
  endgenerate

  // registered pin and mode outputs
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rts_n_o      <= 1'b1;
      gpio_o       <= '0;
      gpio_oe_n_o  <= '1;
      irda_mode_o  <= 1'b0;
      xon_any_o    <= 1'b0;
      thr_access_o <= 1'b0;
    end else begin
      rts_n_o      <= rts_n_nxt;
      gpio_o       <= gpio_nxt;
      gpio_oe_n_o  <= gpio_oe_n_nxt;
      irda_mode_o  <= mlc_r[MLC_IRDA];
      xon_any_o    <= mlc_r[MLC_XANY];
      thr_access_o <= mlc_r[MLC_THR];
    end
  end

endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
// self-checking bench for the modem line control block
module testbench;
  import umcr_pkg::*;
  logic        clock_i, sys_rst_i, avs_read_i, avs_write_i;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdata;
  logic        avs_waitrequest_o, tx_core_i, hw_rts_n_i, rx_core_o;
  logic        baud_tick_o, irda_mode_o, xon_any_o, thr_access_o;
  logic        cts_n_i, dsr_n_i, tx_o, rts_n_o, cts_on, dsr_on, rx_pin;
  logic [7:0]  gpio_i, gpio_o, gpio_oe_n_o;
  int          n_errors, total_checks;

  umcr_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .tx_core_i(tx_core_i),
    .hw_rts_n_i(hw_rts_n_i), .rx_core_o(rx_core_o),
    .baud_tick_o(baud_tick_o), .irda_mode_o(irda_mode_o),
    .xon_any_o(xon_any_o), .thr_access_o(thr_access_o), .rx_i(rx_pin),
    .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i), .tx_o(tx_o),
    .rts_n_o(rts_n_o), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_n_o(gpio_oe_n_o));

  umcr_modem_model modem (.clock_i(clock_i), .cts_on_i(cts_on),
    .dsr_on_i(dsr_on), .pin_drv_i(gpio_o), .pin_oe_n_i(gpio_oe_n_o),
    .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .pin_lvl_o(gpio_i));

  // 250 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, logic [7:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clock_i);
    while (avs_waitrequest_o) @(posedge clock_i);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [4:0] a, logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(nm, rdata, {24'h0, e});
  endtask

  // reset state, write gating, reserved bit, unmapped word
  task automatic t_gate();
    check("rts_n_rst", rts_n_o, 1'b1);
    rdc("mlc_rst", OFF_MLC, 8'h00);
    bus(1'b1, OFF_MLC, 8'hFF);
    rdc("mlc_locked", OFF_MLC, 8'h13);
    bus(1'b1, 5'h1C, 8'hFF);
    rdc("unmapped", 5'h1C, 8'h00);
    bus(1'b1, OFF_EFR, 8'h10);
    bus(1'b1, OFF_MLC, 8'hFF);
    rdc("mlc_open", OFF_MLC, 8'hF7);
    // locked again: zeros written to the gated bits must not land
    bus(1'b1, OFF_EFR, 8'h00);
    bus(1'b1, OFF_MLC, 8'h13);
    rdc("mlc_kept", OFF_MLC, 8'hF7);
    bus(1'b1, OFF_EFR, 8'h10);
    wt(2);
    check("irda", irda_mode_o, 1'b1);
    check("xon_any", xon_any_o, 1'b1);
    check("thr", thr_access_o, 1'b1);
    check("rts_n_on", rts_n_o, 1'b0);
  endtask

  // loopback of serial line and modem bits
  task automatic t_loop();
    tx_core_i <= 1'b0;
    wt(3);
    check("tx_held", tx_o, 1'b1);
    check("rx_looped", rx_core_o, 1'b0);
    rdc("mls_loop", OFF_MLS, 8'h30);
    bus(1'b1, OFF_MLC, 8'h12);
    rdc("mls_rts", OFF_MLS, 8'h10);
    check("irda_off", irda_mode_o, 1'b0);
    check("xon_any_off", xon_any_o, 1'b0);
    check("thr_off", thr_access_o, 1'b0);
    bus(1'b1, OFF_MLC, 8'h00);
    wt(3);
    check("tx_free", tx_o, 1'b0);
    check("rx_pin", rx_core_o, 1'b1);
    rdc("mls_pins", OFF_MLS, 8'h20);
    // pin low with core high: receive input must follow the pin
    tx_core_i <= 1'b1;
    rx_pin <= 1'b0;
    wt(4);
    check("rx_pin_lo", rx_core_o, 1'b0);
    check("tx_core_hi", tx_o, 1'b1);
    rx_pin <= 1'b1;
  endtask

  task automatic ticks(input logic [7:0] mlc, input int exp);
    int n;
    bus(1'b1, OFF_MLC, mlc);
    wt(3);
    n = 0;
    repeat (16) begin
      @(posedge clock_i);
      n = n + baud_tick_o;
    end
    check("ticks", n, exp);
  endtask

  // automatic RTS overrides the control bit
  task automatic t_arts();
    bus(1'b1, OFF_EFR, 8'h50);
    bus(1'b1, OFF_MLC, 8'h02);
    hw_rts_n_i <= 1'b1;
    wt(3);
    check("rts_hw_hi", rts_n_o, 1'b1);
    hw_rts_n_i <= 1'b0;
    bus(1'b1, OFF_MLC, 8'h00);
    wt(3);
    check("rts_hw_lo", rts_n_o, 1'b0);
    bus(1'b1, OFF_EFR, 8'h10);
    wt(3);
    check("rts_bit", rts_n_o, 1'b1);
  endtask

  // general pins serving as DTR
  task automatic t_dtr();
    bus(1'b1, OFF_IODIR, 8'h21);
    bus(1'b1, OFF_IOLVL, 8'hFF);
    bus(1'b1, OFF_MLC, 8'h01);
    wt(3);
    check("pin5_plain", gpio_o[5], 1'b1);
    check("pin1_oe_off", gpio_oe_n_o[1], 1'b1);
    bus(1'b1, OFF_IOCFG, 8'h06);
    wt(3);
    check("pin5_dtr_on", gpio_o[5], 1'b0);
    check("pin1_dtr_on", gpio_o[1], 1'b0);
    check("pin1_oe", gpio_oe_n_o[1], 1'b0);
    // level write of zeros must reach pin 0 only
    bus(1'b1, OFF_MLC, 8'h00);
    bus(1'b1, OFF_IOLVL, 8'h00);
    wt(4);
    check("pin5_dtr_off", gpio_o[5], 1'b1);
    check("pin1_kept", gpio_o[1], 1'b1);
    rdc("pin_levels", OFF_IOLVL, 8'hFE);
  endtask

  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    tx_core_i = 1'b1;
    hw_rts_n_i = 1'b1;
    cts_on = 1'b0;
    dsr_on = 1'b1;
    rx_pin = 1'b1;
    n_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_gate();
    t_loop();
    ticks(8'h80, 4);
    ticks(8'h00, 16);
    t_arts();
    t_dtr();
    report_and_stop();
  end

  // watchdog against a hung handshake
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
endmodule

bind umcr_top umcr_checker u_chk (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .avs_readdata_o(avs_readdata_o), .tx_core_i(tx_core_i), .tx_o(tx_o),
  .irda_mode_o(irda_mode_o), .xon_any_o(xon_any_o),
  .thr_access_o(thr_access_o));

/* verification/umcr_checker.sv */
`timescale 1ns/1ps
// bus timing and control output checks on the top ports
module umcr_checker (
  input wire logic                        clock_i,
  input wire logic                        sys_rst_i,
  input wire logic [umcr_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic                        avs_read_i,
  input wire logic                        avs_write_i,
  input wire logic                        avs_waitrequest_o,
  input wire logic [umcr_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic                        tx_core_i,
  input wire logic                        tx_o,
  input wire logic                        irda_mode_o,
  input wire logic                        xon_any_o,
  input wire logic                        thr_access_o
);
  import umcr_pkg::*;
  // control word access at the answering edge
  wire mlc_hit = avs_address_i[4:2] == 3'h0;
  wire mlc_wr  = avs_write_i && !avs_waitrequest_o && mlc_hit;

  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  chk_wait_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  chk_wait_single: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_wait_idle: assert property (
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("answer without a request");
  chk_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_rsvd_zero: assert property (
    avs_read_i && !avs_waitrequest_o && mlc_hit |-> !avs_readdata_o[3])
    else $error("reserved control bit read as one");
  chk_data_hold: assert property (
    $changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data changed without a read");
  chk_mode_write: assert property (
    $changed({irda_mode_o, xon_any_o, thr_access_o}) |-> $past(mlc_wr, 2))
    else $error("mode output changed without a control write");
  chk_tx_cause: assert property (
    !tx_o |-> !$past(tx_core_i))
    else $error("serial out low without core low");
endmodule

/* verification/umcr_modem_model.sv */
`timescale 1ns/1ps
// far side: modem lines and general pins with pull-ups
module umcr_modem_model (
  input  wire logic       clock_i,
  input  wire logic       cts_on_i,
  input  wire logic       dsr_on_i,
  input  wire logic [7:0] pin_drv_i,
  input  wire logic [7:0] pin_oe_n_i,
  output logic            cts_n_o,
  output logic            dsr_n_o,
  output logic [7:0]      pin_lvl_o
);
  // undriven general pins are pulled high
  assign pin_lvl_o = pin_drv_i | pin_oe_n_i;
  // modem lines are active low
  always_ff @(posedge clock_i) begin
    cts_n_o <= !cts_on_i;
    dsr_n_o <= !dsr_on_i;
  end
endmodule
